// File: sclr_top.sv
// Legacy index/data base register and upper system control fields
`include "sclr_consts.svh"

module sclr_top
  import sclr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic pci_reset_n,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [2:0] cfg_func,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  input wire logic io_valid,
  input wire logic [31:0] io_addr,
  output logic legacy_index_hit,
  output logic legacy_data_hit,
  input wire logic [3:0] func_int_lines,
  output logic [3:0] serial_int_slots,
  output logic [7:0] int_pin_b_report,
  input wire logic switch_clk_in,
  output logic switch_clk_out,
  output logic switch_clk_oe,
  output logic switch_clk_en,
  input wire logic sock_power_wr,
  output logic power_write_smi,
  output logic irq2_pulse,
  output logic card_status_change_irq,
  input wire logic cardbus_present,
  output logic reserved_pin_out,
  output logic reserved_pin_oe,
  output logic supply_protect_en
);
  logic [31:0] base_q;
  logic [1:0] rot_q;
  logic tie_b_q;
  logic tie_all_q;
  logic sw_clk_q;
  logic route_q;
  logic smi_flag_q;
  logic smi_en_q;
  logic rsvd_drv_q;
  logic prot_dis_q;
  logic [31:0] sysctl_rd;
  logic sel_base;
  logic sel_sysctl;
  logic wr_sysctl;
  logic [31:0] sysctl_new;
  logic [1:0] pin_meta_q;
  logic [1:0] pin_sync_q;
  logic ext_clk_last_q;
  logic [3:0] osc_cnt_q;
  logic osc_tick;
  logic osc_level_q;
  logic [31:0] rdata_q;
  logic ack_q;
  logic irq2_q;
  logic csc_q;
  logic [31:0] base_new;

  // Reset word as a vector so its fields can be picked out one by one
  localparam logic [31:0] SYSCTL_RST = `SCLR_SYSCTL_RESET;

  sclr_irq_if irq ();

  ////////////////////////////////////////////////////////////////////////////
  // Merge write data into an old word lane by lane
  function automatic logic [31:0] lane_merge(logic [31:0] old_w, logic [31:0] new_w,
                                             logic [3:0] be);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Only function 0 decodes; other functions see nothing here
  assign sel_base = cfg_func == `SCLR_FUNC_GLOBAL && cfg_addr == `SCLR_OFF_BASE;
  assign sel_sysctl = cfg_func == `SCLR_FUNC_GLOBAL && cfg_addr == `SCLR_OFF_SYSCTL;
  assign wr_sysctl = cfg_wr && sel_sysctl;
  assign sysctl_new = lane_merge(sysctl_rd, cfg_wdata, cfg_be);
  assign base_new = lane_merge(base_q, cfg_wdata, cfg_be);

  ////////////////////////////////////////////////////////////////////////////
  // Legacy base; bit 0 held at one whatever is written
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      base_q <= `SCLR_BASE_RESET;
    end else if (cfg_wr && sel_base) begin
      base_q <= {base_new[31:1], 1'b1};
    end
  end

  // Index at the base word, data one byte above, anywhere in 32-bit space
  assign legacy_index_hit = io_valid && io_addr == {base_q[31:1], 1'b0};
  assign legacy_data_hit = io_valid && io_addr == {base_q[31:1], 1'b1};

  ////////////////////////////////////////////////////////////////////////////
  // Plain control fields; bus reset is deliberately not wired in here
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rot_q <= SYSCTL_RST[`SCLR_ROT_HI:`SCLR_ROT_LO];
      tie_b_q <= SYSCTL_RST[`SCLR_TIE_B];
      tie_all_q <= SYSCTL_RST[`SCLR_TIE_ALL];
      sw_clk_q <= SYSCTL_RST[`SCLR_SW_CLK];
      route_q <= SYSCTL_RST[`SCLR_ROUTE];
      smi_en_q <= SYSCTL_RST[`SCLR_SMI_EN];
      rsvd_drv_q <= SYSCTL_RST[`SCLR_RSVD_DRV];
      prot_dis_q <= SYSCTL_RST[`SCLR_PROT_DIS];
    end else if (wr_sysctl) begin
      rot_q <= sysctl_new[`SCLR_ROT_HI:`SCLR_ROT_LO];
      tie_b_q <= sysctl_new[`SCLR_TIE_B];
      tie_all_q <= sysctl_new[`SCLR_TIE_ALL];
      sw_clk_q <= sysctl_new[`SCLR_SW_CLK];
      route_q <= sysctl_new[`SCLR_ROUTE];
      smi_en_q <= sysctl_new[`SCLR_SMI_EN];
      rsvd_drv_q <= sysctl_new[`SCLR_RSVD_DRV];
      prot_dis_q <= sysctl_new[`SCLR_PROT_DIS];
    end
  end

  // SMI status: a power write with SMI enabled in the clearing cycle still leaves it set
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      smi_flag_q <= SYSCTL_RST[`SCLR_SMI_FLAG];
    end else if (sock_power_wr && smi_en_q) begin
      smi_flag_q <= 1'b1;
    end else if (wr_sysctl && cfg_be[3] && cfg_wdata[`SCLR_SMI_FLAG]) begin
      smi_flag_q <= 1'b0;
    end
  end
  assign power_write_smi = smi_flag_q && smi_en_q;

  // Power-change interrupt steered to one of two pulses
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      irq2_q <= 1'b0;
      csc_q <= 1'b0;
    end else begin
      irq2_q <= sock_power_wr && !route_q;
      csc_q <= sock_power_wr && route_q;
    end
  end
  assign irq2_pulse = irq2_q;
  assign card_status_change_irq = csc_q;

  // Readback; reserved bit 23 is a constant zero, low fields their reset pattern
  assign sysctl_rd = {rot_q, tie_b_q, tie_all_q, sw_clk_q, route_q, smi_flag_q, smi_en_q,
                      1'b0, rsvd_drv_q, prot_dis_q, `SCLR_LOW_FIELDS};

  ////////////////////////////////////////////////////////////////////////////
  // Pins from outside pass two flops before use
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pin_meta_q <= 2'h0;
      pin_sync_q <= 2'h0;
    end else begin
      pin_meta_q <= {cardbus_present, switch_clk_in};
      pin_sync_q <= pin_meta_q;
    end
  end

  // Internal oscillator stand-in: a divider off the reference clock
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      osc_cnt_q <= 4'h0;
      osc_level_q <= 1'b0;
    end else if (osc_tick) begin
      osc_cnt_q <= 4'h0;
      osc_level_q <= !osc_level_q;
    end else begin
      osc_cnt_q <= osc_cnt_q + 4'h1;
    end
  end
  assign osc_tick = osc_cnt_q == `SCLR_OSC_DIV - 4'h1;

  // Edge of the external clock, seen only after synchronising
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ext_clk_last_q <= 1'b0;
    end else begin
      ext_clk_last_q <= pin_sync_q[0];
    end
  end

  // Switch state machine steps on whichever source is chosen
  assign switch_clk_en = sw_clk_q ? (osc_tick && !osc_level_q)
                                  : (pin_sync_q[0] && !ext_clk_last_q);
  assign switch_clk_out = osc_level_q;
  assign switch_clk_oe = sw_clk_q;

  ////////////////////////////////////////////////////////////////////////////
  // Reserved terminals: driven low only with a card in and the bit set
  assign reserved_pin_out = 1'b0;
  assign reserved_pin_oe = rsvd_drv_q && pin_sync_q[1];
  assign supply_protect_en = !prot_dis_q;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt steering in the mapper
  assign irq.lines = func_int_lines;
  assign irq.rotate = rot_q;
  assign irq.tie_b = tie_b_q;
  assign irq.tie_all = tie_all_q;
  assign serial_int_slots = irq.slots;

  sclr_irq_map u_map (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .irq(irq)
  );

  // Second line's pin register value shows the merge
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      int_pin_b_report <= `SCLR_PIN_B_PLAIN;
    end else begin
      int_pin_b_report <= (tie_b_q || tie_all_q) ? `SCLR_PIN_B_TIED
                                                 : `SCLR_PIN_B_PLAIN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read answer one cycle after the request; unmapped reads give zero
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rdata_q <= 32'h00000000;
      ack_q <= 1'b0;
    end else begin
      ack_q <= cfg_rd || cfg_wr;
      if (cfg_rd) begin
        rdata_q <= sel_base ? base_q : (sel_sysctl ? sysctl_rd : 32'h00000000);
      end
    end
  end
  assign cfg_rdata = rdata_q;
  assign cfg_ack = ack_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  base_bit_zero_a: assert property (
    cfg_rd && sel_base |=> cfg_ack && cfg_rdata[0])
    else $error("base bit 0 read as zero");
  base_reset_a: assert property (
    $past(!resetn) |-> base_q == `SCLR_BASE_RESET)
    else $error("base reset value wrong");
  sysctl_reset_a: assert property (
    $past(!resetn) |-> sysctl_rd == `SCLR_SYSCTL_RESET)
    else $error("system control reset value wrong");
  index_decode_a: assert property (
    cfg_wr && sel_base && cfg_be == 4'hF ##1 io_valid && io_addr == {$past(cfg_wdata[31:1]), 1'b0}
      |-> legacy_index_hit && !legacy_data_hit)
    else $error("index port not at written base");
  data_decode_a: assert property (
    io_valid && io_addr == (base_q | 32'h00000001) |-> legacy_data_hit)
    else $error("data port not at base plus one");
  other_func_a: assert property (
    cfg_rd && cfg_func != `SCLR_FUNC_GLOBAL |=> cfg_rdata == 32'h00000000)
    else $error("non-zero function answered");
  smi_set_a: assert property (
    sock_power_wr && smi_en_q |=> smi_flag_q ##1 (smi_flag_q || $past(wr_sysctl)))
    else $error("SMI status not set by power write");
  smi_clear_a: assert property (
    wr_sysctl && cfg_be[3] && cfg_wdata[`SCLR_SMI_FLAG] && !sock_power_wr |=> !smi_flag_q)
    else $error("SMI status not cleared by one");
  route_pulse_a: assert property (
    sock_power_wr |=> (irq2_pulse != card_status_change_irq) && (csc_q == $past(route_q)))
    else $error("power change misrouted");
  rsvd_drive_a: assert property (
    reserved_pin_oe |-> rsvd_drv_q && !reserved_pin_out)
    else $error("reserved terminals driven wrongly");
  bus_reset_keep_a: assert property (
    !pci_reset_n && !wr_sysctl && !sock_power_wr |=> $stable(sysctl_rd))
    else $error("fields disturbed by bus reset");
  bit23_zero_a: assert property (
    wr_sysctl |=> !sysctl_rd[`SCLR_RSVD_BIT])
    else $error("reserved bit 23 not zero");

  // Base moves only on a write; the bus reset never touches it
  base_write_a: assert property (
    cfg_wr && sel_base && cfg_be == 4'hF |=> base_q == {$past(cfg_wdata[31:1]), 1'b1})
    else $error("base not placed where written");
  base_keep_a: assert property (
    !(cfg_wr && sel_base) |=> $stable(base_q))
    else $error("base changed without a write");

  // Switch clock source and its step pulse, one cycle per source edge
  clk_source_a: assert property (
    wr_sysctl && cfg_be[3] |=> switch_clk_oe == $past(cfg_wdata[`SCLR_SW_CLK]))
    else $error("switch clock source not taken from write");
  ext_step_a: assert property (
    !sw_clk_q && switch_clk_en |-> $past(switch_clk_in, 2))
    else $error("switch step without external clock edge");
  step_once_a: assert property (
    switch_clk_en |=> !switch_clk_en || $changed(sw_clk_q))
    else $error("switch step longer than one cycle");

  // SMI status stays clear while the enable is off
  smi_off_a: assert property (
    sock_power_wr && !smi_en_q && !smi_flag_q |=> !smi_flag_q)
    else $error("SMI status set while disabled");
  route_write_a: assert property (
    wr_sysctl && cfg_be[3] |=> route_q == $past(cfg_wdata[`SCLR_ROUTE]))
    else $error("power change route not taken from write");

  // Reserved terminals follow the bit and the card-present pin two flops late
  rsvd_follow_a: assert property (
    rsvd_drv_q && $past(cardbus_present, 2) && $past(resetn, 2) && $past(resetn)
      |-> reserved_pin_oe)
    else $error("reserved terminals not driven with a card in");
  rsvd_release_a: assert property (
    (!rsvd_drv_q || !$past(cardbus_present, 2)) && $past(resetn, 2) && $past(resetn)
      |-> !reserved_pin_oe)
    else $error("reserved terminals driven without card or bit");
  protect_write_a: assert property (
    wr_sysctl && cfg_be[2] |=> supply_protect_en == !$past(cfg_wdata[`SCLR_PROT_DIS]))
    else $error("supply protection not taken from write");

  // Pin register report of either merge
  pin_tied_a: assert property (
    tie_b_q || tie_all_q |=> int_pin_b_report == `SCLR_PIN_B_TIED)
    else $error("merge not reported");
  pin_plain_a: assert property (
    !tie_b_q && !tie_all_q |=> int_pin_b_report == `SCLR_PIN_B_PLAIN)
    else $error("plain pin value not reported");

  // Config answer timing: one ack per strobe, read data held between reads
  ack_once_a: assert property (
    cfg_rd || cfg_wr |=> cfg_ack)
    else $error("access not acknowledged");
  ack_idle_a: assert property (
    !cfg_rd && !cfg_wr |=> !cfg_ack)
    else $error("acknowledge without access");
  rdata_hold_a: assert property (
    !cfg_rd |=> $stable(cfg_rdata))
    else $error("read data changed without a read");

  smi_seen_c: cover property (sock_power_wr && smi_en_q ##1 smi_flag_q);
  rotate_seen_c: cover property (rot_q == 2'h3 && |func_int_lines);
  internal_clk_c: cover property (sw_clk_q && switch_clk_en);
  tie_all_c: cover property (tie_all_q && |serial_int_slots);
  base_moved_c: cover property (cfg_wr && sel_base ##1 legacy_index_hit);
endmodule

// File: sclr_consts.svh
// Offsets, field positions, reset values and counts of the legacy base and system control pair
// Summary of operation
// - Programmed base is the index port; base plus one is the data port.
// - Port pair may sit anywhere in 32-bit I/O space on a word boundary.
// - Base bit 0 is read-only, always reads one, writes ignored.
// - Base register at 44h resets to 0000 0001h, only by global reset.
// - System control at 80h of function 0 resets to 0844 9060h.
// - Two-bit stepping rotates the four interrupt lines by zero to three slots.
// - Bit 29 merges the second line onto the first and reports it.
// - Bit 28 merges all four lines onto the first and reports it.
// - Bit 27 picks switch clock: zero external input, one internal oscillator.
// - Bit 26 routes power-change interrupt: zero to IRQ2, one to status change.
// - Bit 24 enables SMI on socket power writes, resets to zero.
// - Bit 25 sets on power write with SMI enabled; writing one clears.
// - Bit 22 with card present drives reserved terminals low, else released.
// - Bit 21 zero enables supply protection for 16-bit cards, one disables.
// - Upper system control fields cleared only by global reset, not bus reset.
`ifndef SCLR_CONSTS_SVH
`define SCLR_CONSTS_SVH

`define SCLR_OFF_BASE 8'h44
`define SCLR_OFF_SYSCTL 8'h80
`define SCLR_FUNC_GLOBAL 3'h0
`define SCLR_BASE_RESET 32'h00000001
`define SCLR_SYSCTL_RESET 32'h08449060
`define SCLR_LOW_FIELDS 21'h049060
`define SCLR_ROT_HI 31
`define SCLR_ROT_LO 30
`define SCLR_TIE_B 29
`define SCLR_TIE_ALL 28
`define SCLR_SW_CLK 27
`define SCLR_ROUTE 26
`define SCLR_SMI_FLAG 25
`define SCLR_SMI_EN 24
`define SCLR_RSVD_BIT 23
`define SCLR_RSVD_DRV 22
`define SCLR_PROT_DIS 21
`define SCLR_OSC_DIV 4'h4
`define SCLR_PIN_B_PLAIN 8'h02
`define SCLR_PIN_B_TIED 8'h01

`endif

// File: sclr_pkg.sv
// Types shared by the legacy base and system control block
package sclr_pkg;
  typedef logic [1:0] sclr_rot_type;
  typedef logic [3:0] sclr_lines_type;
  typedef enum logic [1:0] {
    SCLR_ROUTE_IRQ2 = 2'b00,
    SCLR_ROUTE_CSC = 2'b01
  } sclr_route_type;
endpackage

// File: sclr_irq_if.sv
// Interrupt steering signals between the register bank and the slot mapper
interface sclr_irq_if;
  import sclr_pkg::*;
  sclr_lines_type lines;
  sclr_rot_type rotate;
  logic tie_b;
  logic tie_all;
  sclr_lines_type slots;
  modport ctl (output lines, output rotate, output tie_b, output tie_all, input slots);
  modport map (input lines, input rotate, input tie_b, input tie_all, output slots);
endinterface

// File: sclr_irq_map.sv
// Interrupt line merging and serial slot rotation
module sclr_irq_map
  import sclr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  sclr_irq_if.map irq
);
  sclr_lines_type merged;
  sclr_lines_type slots_q;

  ////////////////////////////////////////////////////////////////////////////
  // Merge before rotation so a tied line lands in the rotated first slot
  always_comb begin
    merged = irq.lines;
    if (irq.tie_all) begin
      merged = {3'h0, |irq.lines};
    end else if (irq.tie_b) begin
      merged = {irq.lines[3:2], 1'b0, irq.lines[1] | irq.lines[0]};
    end
  end

  // Line i goes to slot i plus the step, modulo four
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      slots_q <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        slots_q[2'(i + int'(irq.rotate))] <= merged[i];
      end
    end
  end

  assign irq.slots = slots_q;

  ////////////////////////////////////////////////////////////////////////////
  rotate_slot_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !irq.tie_b && !irq.tie_all |=> irq.slots[2'($past(irq.rotate))] == $past(irq.lines[0]))
    else $error("first line not in its rotated slot");
  tie_b_merge_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    irq.tie_b && !irq.tie_all && irq.rotate == 2'h0 |=>
      irq.slots[1] == 1'b0 && irq.slots[0] == ($past(irq.lines[0]) | $past(irq.lines[1])))
    else $error("second line not merged onto first");
  tie_all_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    irq.tie_all && irq.rotate == 2'h0 |=> irq.slots == {3'h0, $past(|irq.lines)})
    else $error("four lines not merged onto first");
endmodule

// File: sclr_host.sv
// Host model issuing configuration accesses to the register pair
module sclr_host (
  input wire logic ref_clk,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [2:0] cfg_func,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_ack
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus at time zero
  initial begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_func = 3'h0;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h00000000;
  end

  // One strobe cycle, answer taken at the falling edge half a cycle after the rising edge that took it
  task automatic access(input logic w, input logic [2:0] f, input logic [7:0] a,
                        input logic [3:0] be, input logic [31:0] d,
                        output logic [31:0] q, output logic ack);
    @(negedge ref_clk);
    cfg_wr = w;
    cfg_rd = !w;
    cfg_func = f;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    @(posedge ref_clk);
    @(negedge ref_clk);
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    // Released data shows the inverse so a stale value cannot pass
    cfg_wdata = ~d;
    cfg_func = ~f;
    cfg_addr = ~a;
    cfg_be = ~be;
    q = cfg_rdata;
    ack = cfg_ack;
  endtask
endmodule

// File: tb.sv
// Self-checking bench for the legacy base and system control pair
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, resetn = 1'b0, pci_reset_n = 1'b0, io_valid = 1'b0;
  logic sock_power_wr = 1'b0, cardbus_present = 1'b0, switch_clk_in = 1'b0;
  logic lv;
  logic [31:0] io_addr = 32'h00000000;
  logic [3:0] func_int_lines = 4'h0;
  logic cfg_wr, cfg_rd, cfg_ack, legacy_index_hit, legacy_data_hit;
  logic [2:0] cfg_func;
  logic [7:0] cfg_addr, int_pin_b_report;
  logic [3:0] cfg_be, serial_int_slots;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic switch_clk_out, switch_clk_oe, switch_clk_en, power_write_smi, irq2_pulse;
  logic card_status_change_irq, reserved_pin_out, reserved_pin_oe, supply_protect_en;
  int n_fail = 0, num_checks = 0, cycles = 0;

  sclr_top u_sclr_top (.ref_clk, .resetn, .pci_reset_n, .cfg_wr, .cfg_rd, .cfg_func,
    .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_ack, .io_valid, .io_addr,
    .legacy_index_hit, .legacy_data_hit, .func_int_lines, .serial_int_slots,
    .int_pin_b_report, .switch_clk_in, .switch_clk_out, .switch_clk_oe, .switch_clk_en,
    .sock_power_wr, .power_write_smi, .irq2_pulse, .card_status_change_irq,
    .cardbus_present, .reserved_pin_out, .reserved_pin_oe, .supply_protect_en);

  sclr_host host (.ref_clk, .cfg_wr, .cfg_rd, .cfg_func, .cfg_addr, .cfg_be, .cfg_wdata,
    .cfg_rdata, .cfg_ack);

  // 100 ns clock
  always #50 ref_clk = ~ref_clk;

  // Hang guard, well above the 137 cycles the tests need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [2:0] f, input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    logic [31:0] x;
    logic k;
    host.access(1'b1, f, a, be, d, x, k);
    `CHK("write ack", 1'b1, k)
  endtask

  task automatic rchk(input string nm, input logic [2:0] f, input logic [7:0] a,
                      input logic [31:0] e);
    logic [31:0] q;
    logic k;
    host.access(1'b0, f, a, 4'h0, 32'h00000000, q, k);
    `CHK("read ack", 1'b1, k)
    `CHK(nm, e, q)
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // One-cycle socket power write, ends where the answer pulses stand
  task automatic pwr();
    @(negedge ref_clk);
    sock_power_wr = 1'b1;
    @(negedge ref_clk);
    sock_power_wr = 1'b0;
  endtask

  // Valid stays up between calls so it is never dropped and raised in one step
  task automatic io_hit(input logic [31:0] a, input logic ix, input logic dt);
    io_valid = 1'b1;
    io_addr = a;
    #10;
    `CHK("index hit", ix, legacy_index_hit)
    `CHK("data hit", dt, legacy_data_hit)
    @(negedge ref_clk);
  endtask

  initial begin
    wait_n(16);
    resetn = 1'b1;
    pci_reset_n = 1'b1;
    // Reset values and reset-driven outputs
    rchk("base reset", 3'h0, 8'h44, 32'h00000001);
    rchk("sysctl reset", 3'h0, 8'h80, 32'h08449060);
    `CHK("clk oe", 1'b1, switch_clk_oe)
    `CHK("protect", 1'b1, supply_protect_en)
    `CHK("rsvd oe", 1'b0, reserved_pin_oe)
    lv = switch_clk_out;
    wait_n(4);
    `CHK("osc out", !lv, switch_clk_out)
    $display("test reset done");
    // Base placement, bit 0 fixed, byte lanes and port decode
    wr(3'h0, 8'h44, 4'hF, 32'hFFFFFFFE);
    rchk("base all", 3'h0, 8'h44, 32'hFFFFFFFF);
    wr(3'h0, 8'h44, 4'hF, 32'h00000300);
    rchk("base bit0", 3'h0, 8'h44, 32'h00000301);
    wr(3'h0, 8'h44, 4'h1, 32'hAAAAAAFE);
    rchk("base lane", 3'h0, 8'h44, 32'h000003FF);
    wr(3'h0, 8'h44, 4'hF, 32'h00000300);
    io_hit(32'h00000300, 1'b1, 1'b0);
    io_hit(32'h00000301, 1'b0, 1'b1);
    io_hit(32'h00000302, 1'b0, 1'b0);
    io_hit(32'h00010300, 1'b0, 1'b0);
    io_valid = 1'b0;
    $display("test base done");
    // Other function refused
    wr(3'h1, 8'h44, 4'hF, 32'h12345678);
    rchk("func1 read", 3'h1, 8'h80, 32'h00000000);
    rchk("base kept", 3'h0, 8'h44, 32'h00000301);
    $display("test function done");
    // Full write, then bus reset leaves everything in place
    wr(3'h0, 8'h80, 4'hF, 32'hFFFFFFFF);
    rchk("sysctl all", 3'h0, 8'h80, 32'hFD649060);
    cardbus_present = 1'b1;
    wait_n(4);
    `CHK("rsvd oe", 1'b1, reserved_pin_oe)
    `CHK("rsvd out", 1'b0, reserved_pin_out)
    `CHK("protect", 1'b0, supply_protect_en)
    `CHK("pin report", 8'h01, int_pin_b_report)
    pci_reset_n = 1'b0;
    wait_n(4);
    pci_reset_n = 1'b1;
    rchk("sysctl kept", 3'h0, 8'h80, 32'hFD649060);
    rchk("base kept", 3'h0, 8'h44, 32'h00000301);
    $display("test bus reset done");
    // Slot rotation for every step value
    for (int s = 0; s < 4; s++) begin
      wr(3'h0, 8'h80, 4'h8, {2'(s), 30'h0});
      for (int i = 0; i < 4; i++) begin
        func_int_lines = 4'(1 << i);
        wait_n(2);
        `CHK("slots", 4'(1 << ((i + s) % 4)), serial_int_slots)
      end
    end
    `CHK("pin report", 8'h02, int_pin_b_report)
    `CHK("clk oe", 1'b0, switch_clk_oe)
    switch_clk_in = 1'b1;
    wait_n(2);
    `CHK("ext step", 1'b1, switch_clk_en)
    wait_n(1);
    `CHK("ext once", 1'b0, switch_clk_en)
    switch_clk_in = 1'b0;
    `CHK("rsvd oe", 1'b1, reserved_pin_oe)
    $display("test rotate done");
    // Merge of B onto A, then of all four
    wr(3'h0, 8'h80, 4'h8, 32'h20000000);
    func_int_lines = 4'h2;
    wait_n(2);
    `CHK("tie b", 4'h1, serial_int_slots)
    `CHK("pin report", 8'h01, int_pin_b_report)
    func_int_lines = 4'h4;
    wait_n(2);
    `CHK("tie b c", 4'h4, serial_int_slots)
    wr(3'h0, 8'h80, 4'h8, 32'h10000000);
    func_int_lines = 4'h8;
    wait_n(2);
    `CHK("tie all", 4'h1, serial_int_slots)
    func_int_lines = 4'h0;
    $display("test tie done");
    // Power write routing, enable, status set and clear
    wr(3'h0, 8'h80, 4'h8, 32'h00000000);
    pwr();
    `CHK("irq2", 1'b1, irq2_pulse)
    `CHK("csc", 1'b0, card_status_change_irq)
    `CHK("smi off", 1'b0, power_write_smi)
    wr(3'h0, 8'h80, 4'h8, 32'h05000000);
    pwr();
    `CHK("csc", 1'b1, card_status_change_irq)
    `CHK("irq2", 1'b0, irq2_pulse)
    `CHK("smi on", 1'b1, power_write_smi)
    rchk("smi flag", 3'h0, 8'h80, 32'h07649060);
    wr(3'h0, 8'h80, 4'h8, 32'h07000000);
    `CHK("smi clear", 1'b0, power_write_smi)
    rchk("flag clear", 3'h0, 8'h80, 32'h05649060);
    $display("test power done");
    // Global reset in mid-run brings both registers back
    resetn = 1'b0;
    wait_n(2);
    resetn = 1'b1;
    rchk("sysctl regrst", 3'h0, 8'h80, 32'h08449060);
    rchk("base regrst", 3'h0, 8'h44, 32'h00000001);
    $display("test global reset done");
    give_verdict();
  end
endmodule
